// ==== design/iat_map.vh ====
// Register map, field codes and reset values of the input alarm and trigger block.
// How it works
// (R1) Digital mode: a high input raises the selected alarm class.
// (R2) Analog modes: warning at or below low, at or above high threshold.
// (R3) Analog modes: alarm at or below low, at or above high threshold.
// (R4) Active flags clear only at or past threshold minus or plus hysteresis percent.
// (R5) Event triggers fire their action exactly once per qualifying event.
// (R6) Edge select picks rising, falling or both edges for digital events.
// (R7) Digital level trigger follows input high; action held while set; record on and off codes give no action in digital mode.
// (R8) Edge select has no effect on level triggers.
// (R9) Invert setting complements the input before trigger evaluation.
// (R10) Digital event codes: measure now, transmit, four internal actions.
// (R11) Fast recording: effective interval is record interval divided by factor.
// (R12) Slow recording: effective interval is record interval times factor.
// (R13) Online level trigger holds online mode on; cleared trigger drops it.
// (R14) Analog modes: only transmit is an event; measure now gives no action; the rest are level triggers.
// (R15) Analog level trigger holds while value is at or beyond its level.
// (R16) Input sampled on clock; edges from consecutive samples give one-cycle pulses.
`ifndef IAT_MAP_VH
`define IAT_MAP_VH
`define IAT_REG_CTRL    5'h00
`define IAT_REG_WARN_LO 5'h04
`define IAT_REG_WARN_HI 5'h08
`define IAT_REG_ALRM_LO 5'h0c
`define IAT_REG_ALRM_HI 5'h10
`define IAT_REG_LEVEL   5'h14
`define IAT_REG_RECORD  5'h18
`define IAT_REG_STATUS  5'h1c
// Control register fields.
`define IAT_CTRL_DIGITAL    0
`define IAT_CTRL_INVERT     1
`define IAT_CTRL_EDGE_LSB   2
`define IAT_CTRL_EDGE_MSB   3
`define IAT_CTRL_CLASS_LSB  4
`define IAT_CTRL_CLASS_MSB  5
`define IAT_CTRL_TRIG_LSB   8
`define IAT_CTRL_TRIG_MSB   11
`define IAT_CTRL_GE         12
`define IAT_CTRL_HYST_LSB   16
`define IAT_CTRL_HYST_MSB   22
`define IAT_CTRL_RESET      32'h0000_0000
// Alarm class codes.
`define IAT_CLASS_WARN      2'h0
`define IAT_CLASS_ALARM     2'h1
`define IAT_CLASS_FWARN     2'h2
`define IAT_CLASS_FALARM    2'h3
// Edge selection codes.
`define IAT_EDGE_RISE       2'h0
`define IAT_EDGE_FALL       2'h1
`define IAT_EDGE_BOTH       2'h2
// Trigger action codes.
`define IAT_TRIG_NONE       4'h0
`define IAT_TRIG_MEASURE    4'h1
`define IAT_TRIG_XMIT       4'h2
`define IAT_TRIG_FAST       4'h3
`define IAT_TRIG_SLOW       4'h4
`define IAT_TRIG_REC_ON     4'h5
`define IAT_TRIG_REC_OFF    4'h6
`define IAT_TRIG_ONLINE     4'h7
`define IAT_TRIG_INT1       4'h8
`define IAT_TRIG_INT4       4'hb
`define IAT_HYST_FULL       8'h64
`define IAT_RESP_OKAY       2'h0
`define IAT_RESP_SLVERR     2'h2
`endif

// ==== design/iat_input_alarm_trigger.v ====
// Alarm and trigger evaluation of one universal measurement input.
`timescale 1ns/10ps
`include "iat_map.vh"
module iat_input_alarm_trigger #(
  parameter VW = 16,
  parameter IW = 16,
  parameter FW = 8
) (
  // Clock and reset.
  input  wire          aclk,
  input  wire          aresetn,
  // AXI4-Lite slave.
  input  wire [4:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [4:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Measurement input.
  input  wire          digital_in,
  input  wire [VW-1:0] value_in,
  // Alarm outputs.
  output reg           warning,
  output reg           alarm,
  output reg           fault_warning,
  output reg           fault_alarm,
  // Event pulses.
  output reg           measure_now_event,
  output reg           transmit_event,
  output reg  [3:0]    internal_event,
  // Level actions and effective record interval.
  output reg           fast_record_level,
  output reg           slow_record_level,
  output reg           record_on_level,
  output reg           record_off_level,
  output reg           online_level,
  output reg  [3:0]    internal_level,
  output reg  [IW-1:0] record_interval_eff
);
  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  reg [31:0]   ctrl;
  reg [VW-1:0] warn_lo, warn_hi, alrm_lo, alrm_hi, level_thr;
  reg [IW-1:0] rec_interval;
  reg [FW-1:0] rec_factor;
  wire          dig_mode = ctrl[`IAT_CTRL_DIGITAL];
  wire          inv      = ctrl[`IAT_CTRL_INVERT];
  wire [1:0]    edge_sel = ctrl[`IAT_CTRL_EDGE_MSB:`IAT_CTRL_EDGE_LSB];
  wire [1:0]    cls      = ctrl[`IAT_CTRL_CLASS_MSB:`IAT_CTRL_CLASS_LSB];
  wire [3:0]    trig     = ctrl[`IAT_CTRL_TRIG_MSB:`IAT_CTRL_TRIG_LSB];
  wire          ge_mode  = ctrl[`IAT_CTRL_GE];
  wire [6:0]    hyst     = ctrl[`IAT_CTRL_HYST_MSB:`IAT_CTRL_HYST_LSB];

  // ==========================================================================
  // Input sampling
  // ==========================================================================
  // The pin is asynchronous, so two flops precede any logic.
  reg din_meta, din_sync, din_prev;
  wire din_eff = din_sync ^ inv; // R9
  always @(posedge aclk) begin
    if (!aresetn) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
      din_prev <= 1'b0;
    end else begin
      din_meta <= digital_in;
      din_sync <= din_meta;
      din_prev <= din_eff; // R16
    end
  end
  wire rise = din_eff & ~din_prev; // R16
  wire fall = ~din_eff & din_prev;
  reg edge_hit;
  always @* begin
    case (edge_sel) // R6
      `IAT_EDGE_RISE: edge_hit = rise;
      `IAT_EDGE_FALL: edge_hit = fall;
      `IAT_EDGE_BOTH: edge_hit = rise | fall;
      default:        edge_hit = 1'b0;
    endcase
  end
  // The value is taken to be on the clock domain already (same-clock logic).

  // ==========================================================================
  // Threshold comparison with hysteresis
  // ==========================================================================
  // Band width is threshold * hyst / 100, unsigned; values below zero saturate.
  function [VW-1:0] band;
    input [VW-1:0] thr;
    input [6:0]    h;
    reg   [VW+7:0] p;
    reg   [VW+7:0] q;
    begin
      p    = thr * h;
      q    = p / {{VW{1'b0}}, `IAT_HYST_FULL};
      band = q[VW-1:0];
    end
  endfunction
  // High-side flag: set at or above thr, clear at or below thr minus band.
  function hi_flag;
    input          cur;
    input [VW-1:0] v;
    input [VW-1:0] thr;
    input [6:0]    h;
    reg   [VW-1:0] b;
    begin
      b = band(thr, h);
      // A band wider than the threshold would wrap, so the clear point stops at zero.
      hi_flag = (v >= thr) | (cur & (v > ((b > thr) ? {VW{1'b0}} : thr - b))); // R4
    end
  endfunction
  // Low-side flag: set at or below thr, clear at or above thr plus band.
  function lo_flag;
    input          cur;
    input [VW-1:0] v;
    input [VW-1:0] thr;
    input [6:0]    h;
    reg   [VW:0]   s;
    begin
      s = {1'b0, thr} + {1'b0, band(thr, h)};
      lo_flag = (v <= thr) | (cur & ({1'b0, v} < s)); // R4
    end
  endfunction

  reg wl, wh, al, ah, lv;
  wire next_wl = lo_flag(wl, value_in, warn_lo, hyst);
  wire next_wh = hi_flag(wh, value_in, warn_hi, hyst);
  wire next_al = lo_flag(al, value_in, alrm_lo, hyst);
  wire next_ah = hi_flag(ah, value_in, alrm_hi, hyst);
  wire next_lv = ge_mode ? hi_flag(lv, value_in, level_thr, hyst)   // R15
                         : lo_flag(lv, value_in, level_thr, hyst);
  wire an_prev_lv = lv;
  wire an_rise    = next_lv & ~an_prev_lv;

  // ==========================================================================
  // Action outputs
  // ==========================================================================
  wire act   = dig_mode ? din_eff : next_lv; // R7 R8
  wire evt   = dig_mode ? edge_hit : an_rise; // R5
  wire [3:0] int_idx = trig - `IAT_TRIG_INT1;
  wire is_int = (trig >= `IAT_TRIG_INT1) && (trig <= `IAT_TRIG_INT4);
  wire [IW+FW-1:0] slow_prod = rec_interval * rec_factor;
  wire [FW-1:0]    fdiv = (rec_factor == {FW{1'b0}}) ? {{(FW-1){1'b0}}, 1'b1} : rec_factor;

  always @(posedge aclk) begin
    if (!aresetn) begin
      {wl, wh, al, ah, lv} <= 5'h00;
      warning <= 1'b0;
      alarm <= 1'b0;
      fault_warning <= 1'b0;
      fault_alarm <= 1'b0;
      measure_now_event <= 1'b0;
      transmit_event <= 1'b0;
      internal_event <= 4'h0;
      fast_record_level <= 1'b0;
      slow_record_level <= 1'b0;
      record_on_level <= 1'b0;
      record_off_level <= 1'b0;
      online_level <= 1'b0;
      internal_level <= 4'h0;
      record_interval_eff <= {IW{1'b0}};
    end else begin
      wl <= next_wl & ~dig_mode;
      wh <= next_wh & ~dig_mode;
      al <= next_al & ~dig_mode;
      ah <= next_ah & ~dig_mode;
      lv <= next_lv & ~dig_mode;
      if (dig_mode) begin
        warning       <= din_eff && cls == `IAT_CLASS_WARN; // R1
        alarm         <= din_eff && cls == `IAT_CLASS_ALARM; // R1
        fault_warning <= din_eff && cls == `IAT_CLASS_FWARN;
        fault_alarm   <= din_eff && cls == `IAT_CLASS_FALARM;
      end else begin
        warning       <= next_wl | next_wh; // R2
        alarm         <= next_al | next_ah; // R3
        fault_warning <= 1'b0;
        fault_alarm   <= 1'b0;
      end
      // Digital: measure, transmit and internal codes are events.
      measure_now_event <= dig_mode & evt & (trig == `IAT_TRIG_MEASURE); // R10
      transmit_event    <= evt & (trig == `IAT_TRIG_XMIT); // R5 R14
      internal_event    <= (dig_mode & evt & is_int) ? (4'h1 << int_idx[1:0]) : 4'h0; // R10
      internal_level    <= (~dig_mode & act & is_int) ? (4'h1 << int_idx[1:0]) : 4'h0; // R14
      fast_record_level <= act & (trig == `IAT_TRIG_FAST);
      slow_record_level <= act & (trig == `IAT_TRIG_SLOW);
      record_on_level   <= ~dig_mode & act & (trig == `IAT_TRIG_REC_ON); // R14
      record_off_level  <= ~dig_mode & act & (trig == `IAT_TRIG_REC_OFF);
      online_level      <= act & (trig == `IAT_TRIG_ONLINE); // R13
      if (act && trig == `IAT_TRIG_FAST)
        record_interval_eff <= rec_interval / {{(IW-FW){1'b0}}, fdiv}; // R11
      else if (act && trig == `IAT_TRIG_SLOW)
        record_interval_eff <= slow_prod[IW-1:0]; // R12
      else
        record_interval_eff <= rec_interval;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  // ==========================================================================
  // Address and data are latched independently; response once both are held.
  reg        aw_held, w_held;
  reg [4:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       do_write = aw_held & w_held & ~s_axi_bvalid;
  wire [31:0] st = {25'h0, lv, ah, al, wh, wl, din_eff, dig_mode};
  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (s[i]) merge[i*8 +: 8] = d[i*8 +: 8];
    end
  endfunction
  wire [31:0] wm_ctrl = merge(ctrl, w_data, w_strb);
  wire [31:0] wm_v    = merge(32'h0, w_data, w_strb);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IAT_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      ctrl <= `IAT_CTRL_RESET;
      warn_lo <= {VW{1'b0}};
      warn_hi <= {VW{1'b1}};
      alrm_lo <= {VW{1'b0}};
      alrm_hi <= {VW{1'b1}};
      level_thr <= {VW{1'b1}};
      rec_interval <= {IW{1'b0}};
      rec_factor <= {FW{1'b0}};
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `IAT_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `IAT_RESP_OKAY;
        case ({aw_addr[4:2], 2'b00})
          `IAT_REG_CTRL:    ctrl <= wm_ctrl;
          `IAT_REG_WARN_LO: warn_lo <= wm_v[VW-1:0];
          `IAT_REG_WARN_HI: warn_hi <= wm_v[VW-1:0];
          `IAT_REG_ALRM_LO: alrm_lo <= wm_v[VW-1:0];
          `IAT_REG_ALRM_HI: alrm_hi <= wm_v[VW-1:0];
          `IAT_REG_LEVEL:   level_thr <= wm_v[VW-1:0];
          `IAT_REG_RECORD: begin
            rec_interval <= wm_v[IW-1:0];
            rec_factor <= wm_v[16 +: FW];
          end
          default:          s_axi_bresp <= `IAT_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `IAT_RESP_OKAY;
        case ({s_axi_araddr[4:2], 2'b00})
          `IAT_REG_CTRL:    s_axi_rdata <= ctrl;
          `IAT_REG_WARN_LO: s_axi_rdata <= {{(32-VW){1'b0}}, warn_lo};
          `IAT_REG_WARN_HI: s_axi_rdata <= {{(32-VW){1'b0}}, warn_hi};
          `IAT_REG_ALRM_LO: s_axi_rdata <= {{(32-VW){1'b0}}, alrm_lo};
          `IAT_REG_ALRM_HI: s_axi_rdata <= {{(32-VW){1'b0}}, alrm_hi};
          `IAT_REG_LEVEL:   s_axi_rdata <= {{(32-VW){1'b0}}, level_thr};
          `IAT_REG_RECORD:  s_axi_rdata <= {{(16-FW){1'b0}}, rec_factor, rec_interval};
          `IAT_REG_STATUS:  s_axi_rdata <= st;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `IAT_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // iat_input_alarm_trigger

// ==== tb/iat_input_alarm_trigger_sva.sv ====
// Port-level checker for the input alarm and trigger block.
`timescale 1ns/10ps
module iat_input_alarm_trigger_sva (
  // Clock and reset.
  input wire logic       aclk,
  input wire logic       aresetn,
  // Bus answers.
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Measurement pin.
  input wire logic       digital_in,
  // Events and levels.
  input wire logic       measure_now_event,
  input wire logic       transmit_event,
  input wire logic [3:0] internal_event,
  input wire logic       fast_record_level,
  input wire logic       slow_record_level,
  input wire logic       record_on_level,
  input wire logic       record_off_level,
  input wire logic       online_level,
  input wire logic [3:0] internal_level
);
  logic [8:0] lv;
  assign lv = {fast_record_level, slow_record_level, record_on_level, record_off_level,
               online_level, internal_level};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Event pulses
  property p_meas_pulse; measure_now_event |=> !measure_now_event; endproperty
  a_meas_pulse: assert property (p_meas_pulse) else $error("measure pulse too long");
  property p_xmit_pulse; transmit_event |=> !transmit_event; endproperty
  a_xmit_pulse: assert property (p_xmit_pulse) else $error("transmit pulse too long");
  property p_int_pulse; |internal_event |-> $onehot(internal_event) ##1 internal_event == 4'h0;
  endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("internal pulse wrong");
  // A pin change must lie a few samples behind every measure pulse.
  property p_meas_edge; measure_now_event |-> $past(digital_in, 2) != $past(digital_in, 3)
    || $past(digital_in, 3) != $past(digital_in, 4); endproperty
  a_meas_edge: assert property (p_meas_edge) else $error("measure pulse without edge");
  // ==========================================================
  // Levels
  property p_lv_one; $onehot0(lv); endproperty
  a_lv_one: assert property (p_lv_one) else $error("several level actions");
  property p_evt_nolv; measure_now_event || transmit_event || |internal_event |-> lv == 9'h0;
  endproperty
  a_evt_nolv: assert property (p_evt_nolv) else $error("event beside level");
  // ==========================================================
  // Bus
  property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_once: assert property (p_b_once) else $error("second write answer");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("second read answer");
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
endmodule // iat_input_alarm_trigger_sva
bind iat_input_alarm_trigger iat_input_alarm_trigger_sva i_sva (.aclk, .aresetn, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .digital_in, .measure_now_event,
  .transmit_event, .internal_event, .fast_record_level, .slow_record_level, .record_on_level,
  .record_off_level, .online_level, .internal_level);

// ==== tb/iat_logger_model.sv ====
// Logger control model that counts the event actions the block requests.
`timescale 1ns/10ps
module iat_logger_model (
  // Clock and reset.
  input wire logic       aclk,
  input wire logic       aresetn,
  // Event pulses.
  input wire logic       measure_now_event,
  input wire logic       transmit_event,
  input wire logic [3:0] internal_event,
  // Action counts.
  output logic     [7:0] cnt_meas,
  output logic     [7:0] cnt_xmit,
  output logic     [7:0] cnt_int,
  output logic     [3:0] last_int
);
  // Each pulse cycle is one action, so a stretched pulse shows as extra counts.
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_meas <= 8'h0;
      cnt_xmit <= 8'h0;
      cnt_int <= 8'h0;
      last_int <= 4'h0;
    end else begin
      if (measure_now_event) cnt_meas <= cnt_meas + 8'h1;
      if (transmit_event) cnt_xmit <= cnt_xmit + 8'h1;
      if (|internal_event) cnt_int <= cnt_int + 8'h1;
      if (|internal_event) last_int <= internal_event;
    end
  end
endmodule // iat_logger_model

// ==== tb/iat_input_alarm_trigger_test.sv ====
// Self-checking testbench of the input alarm and trigger block.
`timescale 1ns/10ps
`include "iat_map.vh"
module iat_input_alarm_trigger_test;
  logic        aclk = 0, aresetn = 0, digital_in = 0;
  logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 1, s_axi_rready = 1;
  logic [3:0]  s_axi_wstrb = 4'hf, internal_event, internal_level, last_int;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] value_in = 0, record_interval_eff;
  logic        warning, alarm, fault_warning, fault_alarm, measure_now_event, transmit_event;
  logic        fast_record_level, slow_record_level, record_on_level, record_off_level;
  logic        online_level;
  logic [7:0]  cnt_meas, cnt_xmit, cnt_int;
  int          mismatches = 0, cmp_count = 0;
  // Rows: value, warning, alarm, fast level; warn 100/900, alarm 50/950, level 700, hyst 10.
  logic [18:0] rows [0:15] = '{{16'd500, 3'b000}, {16'd900, 3'b101}, {16'd850, 3'b101},
    {16'd810, 3'b001}, {16'd950, 3'b111}, {16'd900, 3'b111}, {16'd855, 3'b101},
    {16'd640, 3'b001}, {16'd630, 3'b000}, {16'd100, 3'b100}, {16'd105, 3'b100},
    {16'd110, 3'b000}, {16'd50, 3'b110}, {16'd54, 3'b110}, {16'd55, 3'b100},
    {16'd500, 3'b000}};
  logic [3:0]  codes [0:5] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
  iat_input_alarm_trigger i_iat_input_alarm_trigger (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .digital_in, .value_in, .warning,
    .alarm, .fault_warning, .fault_alarm, .measure_now_event, .transmit_event, .internal_event,
    .fast_record_level, .slow_record_level, .record_on_level, .record_off_level, .online_level,
    .internal_level, .record_interval_eff);
  iat_logger_model i_iat_logger_model (.aclk, .aresetn, .measure_now_event, .transmit_event,
    .internal_event, .cnt_meas, .cnt_xmit, .cnt_int, .last_int);
  always #5 aclk = ~aclk;
  // ==========================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ready and response are held high, so the answer edge is the handshake edge.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  // Only the watchdog ends a wait for the answer.
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    chk("rresp", 32'(`IAT_RESP_OKAY), 32'(s_axi_rresp));
  endtask
  task automatic put(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk("bresp", 32'(`IAT_RESP_OKAY), 32'(r));
  endtask
  task automatic pulse();
    digital_in <= 1;
    cyc(6);
    digital_in <= 0;
    cyc(6);
  endtask
  function automatic logic [31:0] cfg(input logic dg, iv, input logic [1:0] ed, cl,
                                      input logic [3:0] tr, input logic ge, input logic [6:0] hy);
    return {9'h0, hy, 3'h0, ge, tr, 2'h0, cl, ed, iv, dg};
  endfunction
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  m0, x0, n0;
    cyc(16);
    aresetn <= 1;
    cyc(1);
    chk("outputs", 32'h0, 32'({warning, alarm, online_level, slow_record_level}));
    rd(`IAT_REG_CTRL, d);
    chk("ctrl", `IAT_CTRL_RESET, d);
    wr(`IAT_REG_STATUS, 32'h1, r);
    chk("status write", 32'(`IAT_RESP_SLVERR), 32'(r));
    put(`IAT_REG_WARN_LO, 32'd100);
    put(`IAT_REG_WARN_HI, 32'd900);
    put(`IAT_REG_ALRM_LO, 32'd50);
    put(`IAT_REG_ALRM_HI, 32'd950);
    put(`IAT_REG_LEVEL, 32'd700);
    put(`IAT_REG_RECORD, {8'h0, 8'd4, 16'd1000});
    put(`IAT_REG_CTRL, cfg(0, 0, 0, 0, `IAT_TRIG_FAST, 1, 10));
    foreach (rows[i]) begin
      value_in <= rows[i][18:3];
      cyc(5);
      chk("warning", 32'(rows[i][2]), 32'(warning));
      chk("alarm", 32'(rows[i][1]), 32'(alarm));
      chk("fast", 32'(rows[i][0]), 32'(fast_record_level));
      chk("interval", rows[i][0] ? 32'd250 : 32'd1000, 32'(record_interval_eff));
    end
    for (int k = 0; k < 4; k++) begin
      put(`IAT_REG_CTRL, cfg(1, 0, 0, k[1:0], `IAT_TRIG_NONE, 0, 0));
      digital_in <= 1;
      cyc(5);
      chk("class", 32'h1 << k, 32'({fault_alarm, fault_warning, alarm, warning}));
      digital_in <= 0;
      cyc(5);
      chk("class off", 32'h0, 32'({fault_alarm, fault_warning, alarm, warning}));
    end
    for (int k = 0; k < 3; k++) begin
      put(`IAT_REG_CTRL, cfg(1, 0, k[1:0], 0, `IAT_TRIG_MEASURE, 0, 0));
      m0 = cnt_meas;
      pulse();
      chk("edges", 32'(m0) + (k == 2 ? 32'd2 : 32'd1), 32'(cnt_meas));
    end
    foreach (codes[i]) begin
      put(`IAT_REG_CTRL, cfg(1, 0, `IAT_EDGE_RISE, 0, codes[i], 0, 0));
      m0 = cnt_meas;
      x0 = cnt_xmit;
      n0 = cnt_int;
      pulse();
      chk("measure", 32'(m0) + 32'(codes[i] == 4'h1), 32'(cnt_meas));
      chk("transmit", 32'(x0) + 32'(codes[i] == 4'h2), 32'(cnt_xmit));
      chk("internal", 32'(n0) + 32'(codes[i][3]), 32'(cnt_int));
      if (codes[i][3]) chk("internal bit", 32'h1 << codes[i][1:0], 32'(last_int));
    end
    put(`IAT_REG_CTRL, cfg(1, 0, `IAT_EDGE_FALL, 0, `IAT_TRIG_SLOW, 0, 0));
    digital_in <= 1;
    cyc(5);
    chk("slow", 32'h1, 32'(slow_record_level));
    chk("slow interval", 32'd4000, 32'(record_interval_eff));
    digital_in <= 0;
    cyc(5);
    chk("slow off", 32'h0, 32'(slow_record_level));
    put(`IAT_REG_CTRL, cfg(1, 1, `IAT_EDGE_FALL, 0, `IAT_TRIG_SLOW, 0, 0));
    cyc(5);
    chk("inverted low", 32'h1, 32'(slow_record_level));
    digital_in <= 1;
    cyc(5);
    chk("inverted high", 32'h0, 32'(slow_record_level));
    put(`IAT_REG_CTRL, cfg(1, 0, `IAT_EDGE_BOTH, 0, `IAT_TRIG_ONLINE, 0, 0));
    cyc(5);
    chk("online", 32'h1, 32'(online_level));
    digital_in <= 0;
    cyc(5);
    chk("online off", 32'h0, 32'(online_level));
    put(`IAT_REG_CTRL, cfg(0, 0, 0, 0, `IAT_TRIG_XMIT, 1, 10));
    x0 = cnt_xmit;
    value_in <= 16'd800;
    cyc(20);
    chk("analog transmit", 32'(x0) + 32'd1, 32'(cnt_xmit));
    put(`IAT_REG_CTRL, cfg(0, 0, 0, 0, 4'h9, 1, 10));
    cyc(5);
    chk("analog internal", 32'h2, 32'(internal_level));
    put(`IAT_REG_CTRL, cfg(0, 0, 0, 0, `IAT_TRIG_REC_ON, 0, 10));
    cyc(5);
    chk("record on idle", 32'h0, 32'(record_on_level));
    value_in <= 16'd700;
    cyc(5);
    chk("record on", 32'h1, 32'(record_on_level));
    value_in <= 16'd760;
    cyc(5);
    chk("record on held", 32'h1, 32'(record_on_level));
    value_in <= 16'd770;
    cyc(5);
    chk("record on clear", 32'h0, 32'(record_on_level));
    put(`IAT_REG_CTRL, cfg(0, 0, 0, 0, `IAT_TRIG_REC_OFF, 1, 10));
    cyc(5);
    chk("record off", 32'h1, 32'(record_off_level));
    rd(`IAT_REG_STATUS, d);
    chk("status", 32'h40, d);
    rd(`IAT_REG_RECORD, d);
    chk("record", 32'h0004_03e8, d);
    // A second reset in mid-run must bring back the idle outputs and registers.
    aresetn <= 0;
    cyc(2);
    aresetn <= 1;
    cyc(3);
    chk("reset outputs", 32'h0,
        32'({warning, alarm, record_off_level, internal_level, record_interval_eff}));
    rd(`IAT_REG_CTRL, d);
    chk("reset ctrl", `IAT_CTRL_RESET, d);
    results();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    results();
  end
endmodule // iat_input_alarm_trigger_test
